/* File: logic/lf_receiver_control_regs.sv */
// Receiver control registers, carrier validation counter and auto-zero pacing
`timescale 1ns/1ns
`include "lfr_params.svh"
module lf_receiver_control_regs (
   input  wire logic        CLK,
   input  wire logic        RESET,
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   input  wire logic        SAMPLE_VALID,
   input  wire logic        CARRIER_DETECTED,
   input  wire logic        DATA_EDGE,
   input  wire logic        DEMOD_DATA,
   input  wire logic        MID_BIT_EDGE,
   input  wire logic        MID_BIT_RISING,
   output logic [1:0]       HYSTERESIS_SEL,
   output logic [1:0]       FILTER_SEL,
   output logic             CARRIER_DETECT_FLAG,
   output logic             RX_CHAIN_START,
   output logic             AUTOZERO_REQ,
   output logic             DECODED_VALID,
   output logic             DECODED_BIT,
   output logic             IRQ
);

   lfr_pkg::state_t st;
   lfr_pkg::state_t next_st;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic paged(input logic [5:0] idx);
      paged = (idx == `OFS_SLICER) || (idx == `OFS_VALIDATION);
   endfunction

   function automatic logic mapped(input logic [5:0] idx);
      mapped = idx <= `OFS_STATE;
   endfunction

   function automatic logic [1:0] resp_of(input logic [5:0] idx, input logic page);
      if (!mapped(idx)) begin
         resp_of = `RESP_DECERR;
      end else if (paged(idx) && !page) begin
         resp_of = `RESP_SLVERR;
      end else begin
         resp_of = `RESP_OKAY;
      end
   endfunction

   function automatic logic [31:0] read_word(input logic [5:0] idx, input lfr_pkg::state_t s);
      read_word = 32'h0000_0000;
      case (idx)
         `OFS_PAGE:       read_word = {31'h0000_0000, s.page};
         `OFS_SLICER:     read_word = s.page ? {24'h00_0000, s.slicer} : 32'h0000_0000;
         `OFS_VALIDATION: read_word = s.page ? {28'h000_0000, s.valid_sel} : 32'h0000_0000;
         `OFS_MODE:       read_word = {28'h000_0000, s.mode_cfg};
         `OFS_STATUS:     read_word = {30'h0000_0000, s.status};
         `OFS_MASK:       read_word = {30'h0000_0000, s.mask};
         `OFS_STATE:      read_word = {23'h00_0000, s.edge_cnt, s.flag, s.car_cnt};
         default:         read_word = 32'h0000_0000;
      endcase
   endfunction

   logic       data_mode;
   logic       toggle_mode;
   logic [1:0] az_trig;
   logic       wr_fire;
   logic       rd_fire;
   logic [5:0] ar_idx;
   logic [4:0] target;
   logic [4:0] cnt_inc;
   logic       az_cond;
   logic [1:0] events;

   assign data_mode   = st.mode_cfg[`MODE_DATA_BIT];
   assign toggle_mode = st.mode_cfg[`MODE_TOGGLE_BIT];
   assign az_trig     = st.mode_cfg[`MODE_AZT_MSB:`MODE_AZT_LSB];
   assign ar_idx      = ARADDR[7:2];
   assign wr_fire     = st.aw_got && st.w_got && !st.bvalid;
   assign rd_fire     = ARVALID && ARREADY;

   // ------------------------------------------------------------
   // Bus handshakes
   // ------------------------------------------------------------
   assign AWREADY = !st.aw_got && !st.bvalid;
   assign WREADY  = !st.w_got && !st.bvalid;
   assign ARREADY = !st.rvalid;
   assign BVALID  = st.bvalid;
   assign BRESP   = st.bresp;
   assign RVALID  = st.rvalid;
   assign RDATA   = st.rdata;
   assign RRESP   = st.rresp;

   assign HYSTERESIS_SEL      = st.slicer[`SLICER_HYSTERESIS_SEL_MSB:`SLICER_HYSTERESIS_SEL_LSB];
   assign FILTER_SEL          = st.slicer[`FILT_MSB:`FILT_LSB];
   assign CARRIER_DETECT_FLAG = st.flag;
   assign RX_CHAIN_START      = st.rx_start;
   assign AUTOZERO_REQ        = st.az_req;
   assign DECODED_VALID       = st.dec_valid;
   assign DECODED_BIT         = st.dec_bit;
   assign IRQ                 = |(st.status & st.mask);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      events  = 2'h0;
      // Data mode takes the target from the count field's reset value, not from valid_sel
      target  = data_mode ? {1'b0, `RST_VALIDATION} + 5'h01
                          : {1'b0, st.valid_sel} + 5'h01;
      cnt_inc = (st.car_cnt == 5'h1f) ? st.car_cnt : st.car_cnt + 5'h01;
      az_cond = 1'b1;

      if (AWVALID && AWREADY) begin
         next_st.aw_got = 1'b1;
         next_st.aw_idx = AWADDR[7:2];
      end
      if (WVALID && WREADY) begin
         next_st.w_got  = 1'b1;
         next_st.w_byte = WDATA[7:0];
         next_st.w_lane = WSTRB[0];
      end
      if (wr_fire) begin
         next_st.aw_got = 1'b0;
         next_st.w_got  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = resp_of(st.aw_idx, st.page);
         if (st.w_lane && resp_of(st.aw_idx, st.page) == `RESP_OKAY) begin
            case (st.aw_idx)
               `OFS_PAGE:       next_st.page      = st.w_byte[0];
               `OFS_SLICER:     next_st.slicer    = st.w_byte;
               `OFS_VALIDATION: next_st.valid_sel = st.w_byte[3:0];
               `OFS_MODE:       next_st.mode_cfg  = st.w_byte[3:0];
               `OFS_MASK:       next_st.mask      = st.w_byte[1:0];
               default:         next_st.mask      = st.mask;
            endcase
         end
      end
      if (st.bvalid && BREADY) begin
         next_st.bvalid = 1'b0;
      end

      if (rd_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = read_word(ar_idx, st);
         next_st.rresp  = resp_of(ar_idx, st.page);
      end else if (st.rvalid && RREADY) begin
         next_st.rvalid = 1'b0;
      end

      // Carrier validation
      next_st.rx_start = 1'b0;
      if (SAMPLE_VALID) begin
         if (!CARRIER_DETECTED) begin
            next_st.car_cnt = 5'h00;
            next_st.flag    = 1'b0;
         end else begin
            // Start-up must not wait for the flag target
            if (st.car_cnt == 5'h00 && !st.flag) begin
               next_st.rx_start = 1'b1;
            end
            if (toggle_mode) begin
               next_st.car_cnt = 5'h00;
               next_st.flag    = 1'b1;
            end else begin
               next_st.car_cnt = cnt_inc;
               if (cnt_inc >= target) begin
                  next_st.flag = 1'b1;
               end
            end
         end
      end
      if (next_st.flag && !st.flag) begin
         events[`ST_CARRIER_BIT] = 1'b1;
      end

      // Auto-zero pacing, data mode only
      next_st.az_req = 1'b0;
      case (az_trig)
         `AZT_DATA_LOW:  az_cond = !DEMOD_DATA;
         `AZT_DATA_HIGH: az_cond = DEMOD_DATA;
         default:        az_cond = 1'b1;
      endcase
      if (!data_mode) begin
         next_st.edge_cnt = 3'h0;
      end else begin
         if (DATA_EDGE && st.edge_cnt != 3'h7) begin
            next_st.edge_cnt = st.edge_cnt + 3'h1;
         end
         if (st.edge_cnt >= st.slicer[`AZ_MSB:`AZ_LSB] && az_cond) begin
            next_st.az_req   = 1'b1;
            next_st.edge_cnt = 3'h0;
            events[`ST_AZ_BIT] = 1'b1;
         end
      end

      // Mid-bit decode in data mode only; carrier mode raises no DECODED_VALID
      next_st.dec_valid = MID_BIT_EDGE && data_mode;
      if (MID_BIT_EDGE && data_mode) begin
         next_st.dec_bit = MID_BIT_RISING ^ st.slicer[`POL_BIT];
      end

      // A new event beats a clearing read in the same cycle
      if (rd_fire && ar_idx == `OFS_STATUS) begin
         next_st.status = events;
      end else begin
         next_st.status = st.status | events;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         st           <= '0;
         st.slicer    <= `RST_SLICER;
         st.valid_sel <= `RST_VALIDATION;
         st.mode_cfg  <= `RST_MODE;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   sequence s_miss;
      SAMPLE_VALID && !CARRIER_DETECTED;
   endsequence

   sequence s_first_hit;
      SAMPLE_VALID && CARRIER_DETECTED && st.car_cnt == 5'h00 && !st.flag;
   endsequence

   a_page_gate: assert property (
      wr_fire && !st.page && st.aw_idx == `OFS_SLICER |=> $stable(st.slicer) && BRESP == `RESP_SLVERR)
      else $error("paged register written with page clear");

   a_slicer_hysteresis_sel_out: assert property (HYSTERESIS_SEL == st.slicer[7:6] && FILTER_SEL == st.slicer[5:4])
      else $error("slicer selects do not follow register");

   a_pol_decode: assert property (
      MID_BIT_EDGE && data_mode
      |=> DECODED_VALID && DECODED_BIT == ($past(MID_BIT_RISING) ^ $past(st.slicer[`POL_BIT])))
      else $error("decoded bit polarity wrong");

   a_carrier_nodec: assert property (!data_mode |=> !DECODED_VALID)
      else $error("decode in carrier mode");

   a_count_clear: assert property (s_miss |=> st.car_cnt == 5'h00 && !CARRIER_DETECT_FLAG)
      else $error("counter not cleared on missing carrier");

   a_flag_target: assert property (
      SAMPLE_VALID && CARRIER_DETECTED && !toggle_mode && !data_mode && !st.flag
      && (st.car_cnt + 5'h01) == ({1'b0, st.valid_sel} + 5'h01) |=> CARRIER_DETECT_FLAG)
      else $error("flag not raised at target count");

   a_flag_early: assert property (
      $rose(CARRIER_DETECT_FLAG) && !$past(toggle_mode) && !$past(data_mode)
      |-> st.car_cnt == {1'b0, $past(st.valid_sel)} + 5'h01)
      else $error("flag raised before target count");

   a_data_target: assert property (
      s_first_hit ##0 data_mode && !toggle_mode |=> CARRIER_DETECT_FLAG)
      else $error("data mode did not use reset count");

   a_rx_start: assert property (s_first_hit |=> RX_CHAIN_START ##1 !RX_CHAIN_START)
      else $error("receiver chain start not pulsed");

   a_toggle_off: assert property (toggle_mode && SAMPLE_VALID |=> st.car_cnt == 5'h00)
      else $error("counter runs in toggle mode");

   a_az_gate: assert property (
      AUTOZERO_REQ && $past(az_trig) == `AZT_DATA_HIGH |-> $past(DEMOD_DATA))
      else $error("auto-zero with data low under trigger 11");

   a_az_spacing: assert property (
      AUTOZERO_REQ |-> $past(st.edge_cnt) >= $past(st.slicer[2:0]))
      else $error("auto-zero before edge count reached");

   a_reserved_zero: assert property (
      rd_fire && ar_idx == `OFS_VALIDATION |=> RDATA[31:4] == 28'h000_0000)
      else $error("reserved bits read nonzero");

   a_irq_level: assert property (IRQ == |(st.status & st.mask))
      else $error("interrupt level mismatch");

   a_unpaged_read: assert property (
      rd_fire && !st.page && paged(ar_idx) |=> RDATA == 32'h0000_0000 && RRESP == `RESP_SLVERR)
      else $error("paged register read with page clear");

   // Reset itself must be watched, so this one is never disabled
   a_pol_reset: assert property (disable iff (1'b0) RESET |=> !st.slicer[`POL_BIT])
      else $error("polarity not cleared by reset");

   a_flag_hold: assert property (CARRIER_DETECT_FLAG && !SAMPLE_VALID |=> CARRIER_DETECT_FLAG)
      else $error("flag dropped without a sample");

   a_flag_status: assert property ($rose(CARRIER_DETECT_FLAG) |-> st.status[`ST_CARRIER_BIT])
      else $error("flag rise not recorded");

   a_az_status: assert property (AUTOZERO_REQ |-> st.status[`ST_AZ_BIT])
      else $error("auto-zero request not recorded");

   a_az_carrier: assert property (!data_mode |=> !AUTOZERO_REQ)
      else $error("auto-zero outside data mode");

   a_az_low_gate: assert property (
      AUTOZERO_REQ && $past(az_trig) == `AZT_DATA_LOW |-> !$past(DEMOD_DATA))
      else $error("auto-zero with data high under trigger 10");

   a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped before handshake");

   a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
      else $error("read data dropped before handshake");

endmodule

/* File: pkg/lfr_params.svh */
// Register map, field positions and reset values of the receiver control bank
`ifndef LFR_PARAMS_SVH
`define LFR_PARAMS_SVH
`define OFS_PAGE        6'h00
`define OFS_SLICER      6'h01
`define OFS_VALIDATION  6'h02
`define OFS_MODE        6'h03
`define OFS_STATUS      6'h04
`define OFS_MASK        6'h05
`define OFS_STATE       6'h06
`define RST_SLICER      8'h00
`define RST_VALIDATION  4'h0
`define RST_MODE        4'h0
`define SLICER_HYSTERESIS_SEL_MSB        7
`define SLICER_HYSTERESIS_SEL_LSB        6
`define FILT_MSB        5
`define FILT_LSB        4
`define POL_BIT         3
`define AZ_MSB          2
`define AZ_LSB          0
`define MODE_DATA_BIT   0
`define MODE_TOGGLE_BIT 1
`define MODE_AZT_MSB    3
`define MODE_AZT_LSB    2
`define AZT_ANY         2'h0
`define AZT_RANDOM      2'h1
`define AZT_DATA_LOW    2'h2
`define AZT_DATA_HIGH   2'h3
`define ST_CARRIER_BIT  0
`define ST_AZ_BIT       1
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define RESP_DECERR     2'h3
`endif

/* File: pkg/lfr_pkg.sv */
// Types shared by the receiver control bank
package lfr_pkg;
   typedef struct packed {
      logic        aw_got;
      logic [5:0]  aw_idx;
      logic        w_got;
      logic [7:0]  w_byte;
      logic        w_lane;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        page;
      logic [7:0]  slicer;
      logic [3:0]  valid_sel;
      logic [3:0]  mode_cfg;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic [4:0]  car_cnt;
      logic        flag;
      logic        rx_start;
      logic [2:0]  edge_cnt;
      logic        az_req;
      logic        dec_valid;
      logic        dec_bit;
   } state_t;
endpackage

/* File: sim/lf_front_end_model.sv */
// Behavioural model of the LF front end driving detector results
`timescale 1ns/1ns
module lf_front_end_model (
   input  wire logic CLK,
   output logic      SAMPLE_VALID,
   output logic      CARRIER_DETECTED,
   output logic      DATA_EDGE,
   output logic      DEMOD_DATA,
   output logic      MID_BIT_EDGE,
   output logic      MID_BIT_RISING
);
   initial begin
      {SAMPLE_VALID, CARRIER_DETECTED, DATA_EDGE} = 3'h0;
      {DEMOD_DATA, MID_BIT_EDGE, MID_BIT_RISING} = 3'h0;
   end
   // Qualified lines show the inverse after a pulse, never a stale value
   task automatic pulse_sample(input logic det);
      SAMPLE_VALID     <= 1'b1;
      CARRIER_DETECTED <= det;
      @(posedge CLK);
      SAMPLE_VALID     <= 1'b0;
      CARRIER_DETECTED <= ~det;
      #1;
   endtask
   task automatic pulse_mid(input logic rising);
      MID_BIT_EDGE   <= 1'b1;
      MID_BIT_RISING <= rising;
      @(posedge CLK);
      MID_BIT_EDGE   <= 1'b0;
      MID_BIT_RISING <= ~rising;
      #1;
   endtask
   task automatic pulse_edge();
      DATA_EDGE <= 1'b1;
      @(posedge CLK);
      DATA_EDGE <= 1'b0;
      #1;
   endtask
   task automatic set_data(input logic d);
      DEMOD_DATA <= d;
   endtask
endmodule

/* File: sim/lf_receiver_control_regs_tb.sv */
// Self-checking bench for the receiver control bank
`timescale 1ns/1ns
`include "lfr_params.svh"
module lf_receiver_control_regs_tb;
   logic        CLK, RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic [7:0]  AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0]  WSTRB;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
   logic [1:0]  BRESP, RRESP, HYSTERESIS_SEL, FILTER_SEL;
   logic        SAMPLE_VALID, CARRIER_DETECTED, DATA_EDGE, DEMOD_DATA;
   logic        MID_BIT_EDGE, MID_BIT_RISING, CARRIER_DETECT_FLAG, RX_CHAIN_START;
   logic        AUTOZERO_REQ, DECODED_VALID, DECODED_BIT;
   localparam logic [7:0] A_PAGE = {`OFS_PAGE, 2'b00};
   localparam logic [7:0] A_SLIC = {`OFS_SLICER, 2'b00};
   localparam logic [7:0] A_VAL  = {`OFS_VALIDATION, 2'b00};
   localparam logic [7:0] A_MODE = {`OFS_MODE, 2'b00};
   localparam logic [7:0] A_STAT = {`OFS_STATUS, 2'b00};
   localparam logic [7:0] A_MASK = {`OFS_MASK, 2'b00};
   localparam logic [7:0] A_STATE = {`OFS_STATE, 2'b00};
   int n_fail, n_checks, az0, k, cnt, flag, tog, dm, vsel;
   int az_seen = 0;
   logic [7:0] v;
   logic [1:0] c;

   lf_receiver_control_regs DUT (
      .CLK                 (CLK),
      .RESET               (RESET),
      .AWADDR              (AWADDR),
      .AWVALID             (AWVALID),
      .AWREADY             (AWREADY),
      .WDATA               (WDATA),
      .WSTRB               (WSTRB),
      .WVALID              (WVALID),
      .WREADY              (WREADY),
      .BRESP               (BRESP),
      .BVALID              (BVALID),
      .BREADY              (BREADY),
      .ARADDR              (ARADDR),
      .ARVALID             (ARVALID),
      .ARREADY             (ARREADY),
      .RDATA               (RDATA),
      .RRESP               (RRESP),
      .RVALID              (RVALID),
      .RREADY              (RREADY),
      .SAMPLE_VALID        (SAMPLE_VALID),
      .CARRIER_DETECTED    (CARRIER_DETECTED),
      .DATA_EDGE           (DATA_EDGE),
      .DEMOD_DATA          (DEMOD_DATA),
      .MID_BIT_EDGE        (MID_BIT_EDGE),
      .MID_BIT_RISING      (MID_BIT_RISING),
      .HYSTERESIS_SEL      (HYSTERESIS_SEL),
      .FILTER_SEL          (FILTER_SEL),
      .CARRIER_DETECT_FLAG (CARRIER_DETECT_FLAG),
      .RX_CHAIN_START      (RX_CHAIN_START),
      .AUTOZERO_REQ        (AUTOZERO_REQ),
      .DECODED_VALID       (DECODED_VALID),
      .DECODED_BIT         (DECODED_BIT),
      .IRQ                 (IRQ)
   );
   lf_front_end_model fe (
      .CLK              (CLK),
      .SAMPLE_VALID     (SAMPLE_VALID),
      .CARRIER_DETECTED (CARRIER_DETECTED),
      .DATA_EDGE        (DATA_EDGE),
      .DEMOD_DATA       (DEMOD_DATA),
      .MID_BIT_EDGE     (MID_BIT_EDGE),
      .MID_BIT_RISING   (MID_BIT_RISING)
   );

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   always @(posedge CLK) if (AUTOZERO_REQ === 1'b1) az_seen <= az_seen + 1;

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tmo(input int i);
      if (i >= 40) begin
         chk("handshake", 1, 0);
         print_verdict();
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      logic ad, wd;
      ad = 0;
      wd = 0;
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1;
      WVALID <= 1;
      BREADY <= 1;
      for (i = 0; i < 40 && !(ad && wd); i++) begin
         @(posedge CLK);
         if (AWVALID && AWREADY) begin ad = 1; AWVALID <= 0; end
         if (WVALID && WREADY) begin wd = 1; WVALID <= 0; end
      end
      tmo(i);
      for (i = 0; i < 40; i++) begin @(posedge CLK); if (BVALID) break; end
      tmo(i);
      BREADY <= 0;
      chk("bresp", er, BRESP);
      // Keeps the next call from driving BREADY in this same time step
      #1;
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                         input string nm);
      int i;
      ARADDR <= a;
      ARVALID <= 1;
      RREADY <= 1;
      for (i = 0; i < 40; i++) begin @(posedge CLK); if (ARREADY) break; end
      tmo(i);
      ARVALID <= 0;
      for (i = 0; i < 40; i++) begin @(posedge CLK); if (RVALID) break; end
      tmo(i);
      RREADY <= 0;
      chk(nm, ed, RDATA);
      chk(nm, er, RRESP);
      #1;
   endtask
   // Reference of the validation counter, advanced per sample
   task automatic samp(input logic det);
      int tgt, rx;
      fe.pulse_sample(det);
      tgt = dm ? 1 : vsel + 1;
      rx = det && cnt == 0 && !flag;
      if (!det) cnt = 0;
      else if (tog) cnt = 0;
      else if (cnt < 31) cnt++;
      flag = det && (tog || cnt >= tgt);
      chk("flag", flag, CARRIER_DETECT_FLAG);
      chk("rx_start", rx, RX_CHAIN_START);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {RESET, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h20;
      {AWADDR, ARADDR, WDATA, WSTRB} = {16'h0, 32'h0, 4'hf};
      {n_fail, n_checks, cnt, flag, tog, dm, vsel} = '0;
      void'($urandom(58));
      repeat (20) @(posedge CLK);
      RESET <= 0;
      @(posedge CLK);
      #1;
      axi_wr(A_SLIC, 32'hc0, `RESP_SLVERR);
      axi_rd(A_SLIC, 0, `RESP_SLVERR, "slicer_unpaged");
      axi_wr(A_PAGE, 1, `RESP_OKAY);
      axi_rd(A_SLIC, `RST_SLICER, `RESP_OKAY, "slicer_reset");
      axi_rd(A_VAL, `RST_VALIDATION, `RESP_OKAY, "valid_reset");
      axi_rd(8'h1c, 0, `RESP_DECERR, "unmapped");
      axi_wr(A_VAL, 32'hff, `RESP_OKAY);
      axi_rd(A_VAL, 32'h0f, `RESP_OKAY, "valid_reserved");
      for (k = 0; k < 4; k++) begin
         c = k[1:0];
         v = {c, c, 4'($urandom)};
         axi_wr(A_SLIC, {24'h0, v}, `RESP_OKAY);
         axi_rd(A_SLIC, {24'h0, v}, `RESP_OKAY, "slicer");
         chk("hysteresis", c, HYSTERESIS_SEL);
         chk("filter", c, FILTER_SEL);
      end
      axi_wr(A_MASK, 1, `RESP_OKAY);
      for (k = 0; k < 3; k++) begin
         vsel = (k == 0) ? 0 : (k == 1) ? 2 : 15;
         axi_wr(A_VAL, vsel, `RESP_OKAY);
         samp(0);
         repeat (vsel) samp(1);
         samp(0);
         repeat (vsel + 2) samp(1);
         chk("irq", 1, IRQ);
         axi_rd(A_STAT, 1, `RESP_OKAY, "status");
         chk("irq_cleared", 0, IRQ);
      end
      // Toggle mode with the interrupt masked off
      axi_wr(A_MASK, 0, `RESP_OKAY);
      axi_wr(A_MODE, 2, `RESP_OKAY);
      tog = 1;
      samp(0);
      samp(1);
      samp(1);
      chk("irq_masked", 0, IRQ);
      axi_rd(A_STAT, 1, `RESP_OKAY, "status_masked");
      axi_wr(A_MODE, 1, `RESP_OKAY);
      {tog, dm} = {32'h0, 32'h1};
      samp(0);
      samp(1);
      samp(1);
      for (k = 0; k < 4; k++) begin
         axi_wr(A_SLIC, {24'h0, 2'h3, 2'h0, k[1], 3'h6}, `RESP_OKAY);
         fe.pulse_mid(k[0]);
         chk("dec_valid", 1, DECODED_VALID);
         chk("dec_bit", k[0] ^ k[1], DECODED_BIT);
      end
      axi_wr(A_MODE, 0, `RESP_OKAY);
      fe.pulse_mid(1);
      chk("dec_carrier", 0, DECODED_VALID);
      axi_wr(A_MODE, 32'h0d, `RESP_OKAY);
      fe.set_data(0);
      az0 = az_seen;
      repeat (8) fe.pulse_edge();
      repeat (3) @(posedge CLK);
      #1;
      chk("az_data_low", az0, az_seen);
      fe.set_data(1);
      repeat (3) @(posedge CLK);
      #1;
      chk("az_data_high", az0 + 1, az_seen);
      repeat (5) fe.pulse_edge();
      repeat (3) @(posedge CLK);
      #1;
      chk("az_five_edges", az0 + 1, az_seen);
      fe.pulse_edge();
      repeat (3) @(posedge CLK);
      #1;
      chk("az_six_edges", az0 + 2, az_seen);
      axi_rd(A_STAT, 3, `RESP_OKAY, "status_az");
      // Trigger 10: edges counted, request waits for data low
      axi_wr(A_MODE, 32'h09, `RESP_OKAY);
      az0 = az_seen;
      repeat (6) fe.pulse_edge();
      repeat (3) @(posedge CLK);
      #1;
      chk("az_low_blocked", az0, az_seen);
      fe.set_data(0);
      repeat (3) @(posedge CLK);
      #1;
      chk("az_low_fires", az0 + 1, az_seen);
      // Mid-run reset with polarity set
      RESET <= 1;
      repeat (3) @(posedge CLK);
      RESET <= 0;
      @(posedge CLK);
      #1;
      axi_wr(A_PAGE, 1, `RESP_OKAY);
      axi_rd(A_SLIC, `RST_SLICER, `RESP_OKAY, "slicer_rereset");
      axi_rd(A_STATE, 0, `RESP_OKAY, "state_rereset");
      WSTRB <= 4'he;
      axi_wr(A_VAL, 32'h5, `RESP_OKAY);
      WSTRB <= 4'hf;
      axi_rd(A_VAL, `RST_VALIDATION, `RESP_OKAY, "valid_lane_off");
      print_verdict();
   end
   initial begin
      #800000;
      chk("run_time", 0, 1);
      print_verdict();
   end
endmodule
